// ===== inc/etcb_pkg.sv
// Register map, field layout and code constants of the timer channel B block
package etcb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register word indices (byte address is four times the index)
   localparam logic [3:0] IDX_CTRL0 = 4'h0;
   localparam logic [3:0] IDX_CTRL1 = 4'h1;
   localparam logic [3:0] IDX_CTRL2 = 4'h2;
   localparam logic [3:0] IDX_CNTL  = 4'h3;
   localparam logic [3:0] IDX_CNTH  = 4'h4;
   localparam logic [3:0] IDX_CMPAL = 4'h5;
   localparam logic [3:0] IDX_CMPAH = 4'h6;
   localparam logic [3:0] IDX_CMPBL = 4'h7;
   localparam logic [3:0] IDX_CMPBH = 4'h8;
   localparam logic [3:0] IDX_FLAG  = 4'h9;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int C0_ON_BIT   = 3;
   localparam int C0_PER_LSB  = 0;
   localparam int CX_MODE_LSB = 6;
   localparam int CX_PINF_LSB = 4;
   localparam int CX_LVL_BIT  = 3;
   localparam int CX_INV_BIT  = 2;
   localparam int C1_DIR_BIT  = 1;
   localparam int C1_CCS_BIT  = 0;
   localparam int C2_ALN_LSB  = 0;
   localparam int FLG_A       = 0;
   localparam int FLG_B       = 1;
   localparam int FLG_P       = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Channel modes
   localparam logic [1:0] MD_CMP = 2'h0;
   localparam logic [1:0] MD_CAP = 2'h1;
   localparam logic [1:0] MD_PWM = 2'h2;
   localparam logic [1:0] MD_TMR = 2'h3;

   // Pin function codes, compare mode
   localparam logic [1:0] PF_LOW  = 2'h1;
   localparam logic [1:0] PF_HIGH = 2'h2;
   localparam logic [1:0] PF_TOG  = 2'h3;
   // Pin function codes, PWM / single pulse mode
   localparam logic [1:0] PF_INACT = 2'h0;
   localparam logic [1:0] PF_ACT   = 2'h1;
   localparam logic [1:0] PF_PWM   = 2'h2;
   localparam logic [1:0] PF_SP    = 2'h3;
   // Pin function codes, capture mode
   localparam logic [1:0] CF_RISE = 2'h0;
   localparam logic [1:0] CF_FALL = 2'h1;
   localparam logic [1:0] CF_BOTH = 2'h2;

   // PWM alignment
   localparam logic [1:0] AL_EDGE = 2'h0;
   localparam logic [1:0] AL_UP   = 2'h1;
   localparam logic [1:0] AL_DN   = 2'h2;

endpackage

// ===== inc/etcb_pin_if.sv
// Carrier between the channel B core and its output pin stage
`timescale 1ns/1ps
interface etcb_pin_if;
   logic [1:0] mode;
   logic [1:0] pinf;
   logic       lvl;
   logic       inv;
   logic       match;
   logic       on_rise;
   logic       pwm_act;
   logic       sp_act;
   logic       out;
   logic       out_n;

   modport core (output mode, pinf, lvl, inv, match, on_rise, pwm_act, sp_act,
                 input  out, out_n);
   modport pin  (input  mode, pinf, lvl, inv, match, on_rise, pwm_act, sp_act,
                 output out, out_n);
endinterface

// ===== verilog/etcb_pin.sv
// Channel B output pin stage: level, forcing, polarity and complement pin
`timescale 1ns/1ps
module etcb_pin (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Core side
   etcb_pin_if.pin   pif
);

   typedef struct packed {
      logic lvl;
      logic out;
      logic out_n;
   } etcb_pin_s;

   etcb_pin_s p_q;
   etcb_pin_s p_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      p_d = p_q;
      case (pif.mode)
         etcb_pkg::MD_CMP: begin
            if (pif.on_rise) begin
               p_d.lvl = pif.lvl;
            end else if (pif.match) begin
               // Same level as present gives no visible change
               case (pif.pinf)
                  etcb_pkg::PF_LOW:  p_d.lvl = 1'b0;
                  etcb_pkg::PF_HIGH: p_d.lvl = 1'b1;
                  etcb_pkg::PF_TOG:  p_d.lvl = ~p_q.lvl;
                  default:           p_d.lvl = p_q.lvl;
               endcase
            end
         end
         etcb_pkg::MD_PWM: begin
            case (pif.pinf)
               etcb_pkg::PF_INACT: p_d.lvl = ~pif.lvl;
               etcb_pkg::PF_ACT:   p_d.lvl = pif.lvl;
               etcb_pkg::PF_PWM:   p_d.lvl = pif.pwm_act ? pif.lvl : ~pif.lvl;
               default:            p_d.lvl = pif.sp_act ? pif.lvl : ~pif.lvl;
            endcase
         end
         default: p_d.lvl = p_q.lvl;
      endcase
      if (pif.mode == etcb_pkg::MD_TMR) begin
         p_d.out   = 1'b0;
         p_d.out_n = 1'b0;
      end else begin
         p_d.out   = p_d.lvl ^ pif.inv;
         p_d.out_n = ~p_d.lvl ^ pif.inv;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p_q <= '0;
      end else begin
         p_q <= p_d;
      end
   end

   assign pif.out   = p_q.out;
   assign pif.out_n = p_q.out_n;

   ////////////////////////////////////////////////////////////////////////////
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_PIN_HIGH: assert property (
      pif.mode == etcb_pkg::MD_CMP && !pif.on_rise && pif.match && pif.pinf == etcb_pkg::PF_HIGH
      |=> p_q.lvl && pif.out == !$past(pif.inv)
   ) else $error("Compare high did not drive the pin high");

   AST_PIN_INIT: assert property (
      pif.mode == etcb_pkg::MD_CMP && pif.on_rise |=> p_q.lvl == $past(pif.lvl)
   ) else $error("Timer on rise did not restore the initial level");

   AST_PWM_FORCE: assert property (
      pif.mode == etcb_pkg::MD_PWM && pif.pinf == etcb_pkg::PF_ACT
      |=> pif.out == ($past(pif.lvl) ^ $past(pif.inv)) && pif.out_n != pif.out
   ) else $error("Forced active level not on the pins");

   AST_TMR_OUT: assert property (
      pif.mode == etcb_pkg::MD_TMR |=> !pif.out && !pif.out_n
   ) else $error("Pins moved in timer/counter mode");

   COV_TOGGLE: cover property (
      pif.mode == etcb_pkg::MD_CMP && pif.match && pif.pinf == etcb_pkg::PF_TOG
   );

endmodule

// ===== verilog/etcb_top.sv
// Channel B compare/capture core of the 10-bit enhanced timer, Avalon-MM slave
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module etcb_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Selected timer clock as a one-cycle enable
   input  wire logic        tick_i,
   // Channel B capture input
   input  wire logic        capture_b_input_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Output pins
   output logic             out_a_pin_o,
   output logic             out_b_pin_o,
   output logic             out_b_comp_pin_o,
   // Match flags
   output logic             match_a_flag_o,
   output logic             match_b_flag_o,
   output logic             period_match_flag_o
);

   typedef struct packed {
      logic [7:0]  c0;
      logic [7:0]  c1;
      logic [7:0]  c2;
      logic [9:0]  cnt;
      logic [9:0]  cmpa;
      logic [9:0]  cmpb;
      logic [2:0]  flg;
      logic        on_prev;
      logic        dir_dn;
      logic        cap_prev;
      logic        sp_act;
      logic        ack;
      logic        lvl_a;
      logic        out_a;
      logic [31:0] rdata;
   } etcb_core_s;

   localparam etcb_core_s CORE_RST = '{
      c0:      etcb_pkg::RST_BYTE,
      c1:      etcb_pkg::RST_BYTE,
      c2:      etcb_pkg::RST_BYTE,
      default: '0
   };

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Last count of the period; period zero wraps to the overflow point
   function automatic logic per_match(input logic [9:0] c, input logic [2:0] p);
      logic [2:0] nx;
      nx = c[9:7] + 3'h1;
      return (nx == p) && (c[6:0] == 7'h7f);
   endfunction

   function automatic logic dir_ok(input logic [1:0] al, input logic dn);
      logic ok;
      ok = 1'b1;
      case (al)
         etcb_pkg::AL_UP: ok = !dn;
         etcb_pkg::AL_DN: ok = dn;
         default:         ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic cap_edge(input logic [1:0] pf, input logic pv, input logic nw);
      logic hit;
      hit = 1'b0;
      case (pf)
         etcb_pkg::CF_RISE: hit = nw & ~pv;
         etcb_pkg::CF_FALL: hit = ~nw & pv;
         etcb_pkg::CF_BOTH: hit = nw ^ pv;
         default:           hit = 1'b0;
      endcase
      return hit;
   endfunction

   function automatic logic [31:0] rd_word(input etcb_core_s c, input logic [3:0] a);
      logic [7:0] b;
      b = 8'h00;
      if (a == etcb_pkg::IDX_CTRL0) begin
         b = c.c0;
      end else if (a == etcb_pkg::IDX_CTRL1) begin
         b = {c.c1[7:2], c.dir_dn, c.c1[0]};
      end else if (a == etcb_pkg::IDX_CTRL2) begin
         b = c.c2;
      end else if (a == etcb_pkg::IDX_CNTL) begin
         b = c.cnt[7:0];
      end else if (a == etcb_pkg::IDX_CNTH) begin
         b = {6'h00, c.cnt[9:8]};
      end else if (a == etcb_pkg::IDX_CMPAL) begin
         b = c.cmpa[7:0];
      end else if (a == etcb_pkg::IDX_CMPAH) begin
         b = {6'h00, c.cmpa[9:8]};
      end else if (a == etcb_pkg::IDX_CMPBL) begin
         b = c.cmpb[7:0];
      end else if (a == etcb_pkg::IDX_CMPBH) begin
         b = {6'h00, c.cmpb[9:8]};
      end else if (a == etcb_pkg::IDX_FLAG) begin
         b = {5'h00, c.flg};
      end
      return {24'h00_0000, b};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic [1:0] rsync_q;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsync_q <= 2'b00;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end

   assign rst_n = rsync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Decoded state
   etcb_core_s s_q;
   etcb_core_s s_d;

   logic       on;
   logic       on_rise;
   logic       run;
   logic       ccs;
   logic       am;
   logic       bm;
   logic       pm;
   logic       cap_hit;
   logic       bus_wr;
   logic [1:0] md_a;
   logic [1:0] pf_a;
   logic [1:0] md_b;
   logic [1:0] pf_b;
   logic [1:0] aln;
   logic [2:0] per;
   logic [2:0] set_f;
   logic [2:0] clr_f;

   assign on      = s_q.c0[etcb_pkg::C0_ON_BIT];
   assign on_rise = on & ~s_q.on_prev;
   assign run     = on & tick_i & ~on_rise;
   assign per     = s_q.c0[etcb_pkg::C0_PER_LSB +: 3];
   assign ccs     = s_q.c1[etcb_pkg::C1_CCS_BIT];
   assign md_a    = s_q.c1[etcb_pkg::CX_MODE_LSB +: 2];
   assign pf_a    = s_q.c1[etcb_pkg::CX_PINF_LSB +: 2];
   assign md_b    = s_q.c2[etcb_pkg::CX_MODE_LSB +: 2];
   assign pf_b    = s_q.c2[etcb_pkg::CX_PINF_LSB +: 2];
   assign aln     = s_q.c2[etcb_pkg::C2_ALN_LSB +: 2];
   assign am      = (s_q.cnt == s_q.cmpa);
   assign bm      = (s_q.cnt == s_q.cmpb);
   assign pm      = per_match(s_q.cnt, per);
   assign cap_hit = cap_edge(pf_b, s_q.cap_prev, capture_b_input_i);
   assign bus_wr  = avs_write_i & s_q.ack & avs_byteenable_i[0];

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      set_f = 3'h0;
      clr_f = 3'h0;
      s_d.on_prev = on;
      s_d.cap_prev = capture_b_input_i;

      if (on_rise) begin
         s_d.cnt = 10'h000;
         s_d.dir_dn = 1'b0;
         s_d.sp_act = 1'b0;
      end else if (run) begin
         case (md_b)
            etcb_pkg::MD_CMP, etcb_pkg::MD_TMR: begin
               set_f[etcb_pkg::FLG_A] = am;
               set_f[etcb_pkg::FLG_B] = bm;
               if (ccs) begin
                  s_d.cnt = am ? 10'h000 : s_q.cnt + 10'h001;
               end else begin
                  set_f[etcb_pkg::FLG_P] = pm;
                  s_d.cnt = pm ? 10'h000 : s_q.cnt + 10'h001;
               end
            end
            etcb_pkg::MD_PWM: begin
               set_f[etcb_pkg::FLG_A] = am & dir_ok(aln, s_q.dir_dn);
               set_f[etcb_pkg::FLG_B] = bm & dir_ok(aln, s_q.dir_dn);
               // Period comes from the period bits only here
               if (aln == etcb_pkg::AL_EDGE) begin
                  set_f[etcb_pkg::FLG_P] = pm;
                  s_d.cnt = pm ? 10'h000 : s_q.cnt + 10'h001;
               end else if (!s_q.dir_dn) begin
                  if (pm) begin
                     s_d.dir_dn = 1'b1;
                     s_d.cnt = s_q.cnt - 10'h001;
                  end else begin
                     s_d.cnt = s_q.cnt + 10'h001;
                  end
               end else begin
                  s_d.cnt = s_q.cnt - 10'h001;
                  if (s_q.cnt == 10'h001) begin
                     s_d.dir_dn = 1'b0;
                     set_f[etcb_pkg::FLG_P] = 1'b1;
                  end
               end
               // Single pulse: B match starts it, A match ends it and stops the timer
               if (pf_b == etcb_pkg::PF_SP) begin
                  if (bm) begin
                     s_d.sp_act = 1'b1;
                  end
                  if (am) begin
                     s_d.sp_act = 1'b0;
                     s_d.c0[etcb_pkg::C0_ON_BIT] = 1'b0;
                  end
               end
            end
            default: begin
               set_f[etcb_pkg::FLG_P] = pm;
               s_d.cnt = pm ? 10'h000 : s_q.cnt + 10'h001;
            end
         endcase
      end

      if (md_b == etcb_pkg::MD_CAP && on && cap_hit) begin
         s_d.cmpb = s_q.cnt;
         set_f[etcb_pkg::FLG_B] = 1'b1;
      end
      if (!on) begin
         s_d.sp_act = 1'b0;
      end

      // Channel A pin in compare mode
      if (md_a == etcb_pkg::MD_CMP) begin
         if (on_rise) begin
            s_d.lvl_a = s_q.c1[etcb_pkg::CX_LVL_BIT];
         end else if (set_f[etcb_pkg::FLG_A]) begin
            case (pf_a)
               etcb_pkg::PF_LOW:  s_d.lvl_a = 1'b0;
               etcb_pkg::PF_HIGH: s_d.lvl_a = 1'b1;
               etcb_pkg::PF_TOG:  s_d.lvl_a = ~s_q.lvl_a;
               default:           s_d.lvl_a = s_q.lvl_a;
            endcase
         end
      end
      s_d.out_a = s_d.lvl_a ^ s_q.c1[etcb_pkg::CX_INV_BIT];

      // Bus: one wait state, read data loaded on the first edge
      s_d.ack = (avs_read_i | avs_write_i) & ~s_q.ack;
      if (avs_read_i && !s_q.ack) begin
         s_d.rdata = rd_word(s_q, avs_address_i);
      end
      if (bus_wr) begin
         if (avs_address_i == etcb_pkg::IDX_CTRL0) begin
            s_d.c0 = avs_writedata_i[7:0];
         end else if (avs_address_i == etcb_pkg::IDX_CTRL1) begin
            s_d.c1 = avs_writedata_i[7:0];
         end else if (avs_address_i == etcb_pkg::IDX_CTRL2) begin
            s_d.c2 = avs_writedata_i[7:0];
         end else if (avs_address_i == etcb_pkg::IDX_CMPAL) begin
            s_d.cmpa[7:0] = avs_writedata_i[7:0];
         end else if (avs_address_i == etcb_pkg::IDX_CMPAH) begin
            s_d.cmpa[9:8] = avs_writedata_i[1:0];
         end else if (avs_address_i == etcb_pkg::IDX_CMPBL) begin
            s_d.cmpb[7:0] = avs_writedata_i[7:0];
         end else if (avs_address_i == etcb_pkg::IDX_CMPBH) begin
            s_d.cmpb[9:8] = avs_writedata_i[1:0];
         end else if (avs_address_i == etcb_pkg::IDX_FLAG) begin
            clr_f = avs_writedata_i[2:0];
         end
      end

      // A new match wins over a clear in the same cycle
      s_d.flg = (s_q.flg & ~clr_f) | set_f;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= CORE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel B pin stage
   etcb_pin_if pif ();

   assign pif.mode    = md_b;
   assign pif.pinf    = pf_b;
   assign pif.lvl     = s_q.c2[etcb_pkg::CX_LVL_BIT];
   assign pif.inv     = s_q.c2[etcb_pkg::CX_INV_BIT];
   assign pif.match   = set_f[etcb_pkg::FLG_B];
   assign pif.on_rise = on_rise;
   assign pif.pwm_act = (s_q.cnt < s_q.cmpb);
   assign pif.sp_act  = s_q.sp_act;

   etcb_pin u_pin (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .pif     (pif.pin)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_waitrequest_o   = (avs_read_i | avs_write_i) & ~s_q.ack;
   assign avs_readdata_o      = s_q.rdata;
   assign out_a_pin_o         = s_q.out_a;
   assign out_b_pin_o         = pif.out;
   assign out_b_comp_pin_o    = pif.out_n;
   assign match_a_flag_o      = s_q.flg[etcb_pkg::FLG_A];
   assign match_b_flag_o      = s_q.flg[etcb_pkg::FLG_B];
   assign period_match_flag_o = s_q.flg[etcb_pkg::FLG_P];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   AST_CLR_A: assert property (
      md_b == etcb_pkg::MD_CMP && ccs && run && am |=> s_q.cnt == 10'h000
   ) else $error("Compare A match did not clear the counter");

   AST_CLR_P: assert property (
      md_b == etcb_pkg::MD_CMP && !ccs && run && pm
      |=> s_q.cnt == 10'h000 && s_q.flg[etcb_pkg::FLG_P]
   ) else $error("Period match did not clear the counter");

   AST_IGN_CCS: assert property (
      md_b == etcb_pkg::MD_PWM && aln == etcb_pkg::AL_EDGE && ccs && run && am && !pm
      |=> s_q.cnt == $past(s_q.cnt) + 10'h001
   ) else $error("Clear select acted in PWM mode");

   AST_ON_RST: assert property (
      on_rise |=> s_q.cnt == 10'h000 ##1 s_q.on_prev
   ) else $error("Timer on rise did not zero the counter");

   AST_OFF_HOLD: assert property (
      !on |=> $stable(s_q.cnt)
   ) else $error("Counter moved while the timer was off");

   AST_NO_PF: assert property (
      md_b == etcb_pkg::MD_CMP && ccs && !s_q.flg[etcb_pkg::FLG_P] |=> !s_q.flg[etcb_pkg::FLG_P]
   ) else $error("Period flag raised with clear select high");

   AST_FLAG_HOLD: assert property (
      s_q.flg[etcb_pkg::FLG_A] && !(bus_wr && avs_address_i == etcb_pkg::IDX_FLAG && avs_writedata_i[0])
      |=> s_q.flg[etcb_pkg::FLG_A]
   ) else $error("Match A flag dropped without a clear");

   AST_CNTH_RD: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i == etcb_pkg::IDX_CNTH
      |-> avs_readdata_o[31:2] == 30'h0000_0000 && avs_readdata_o[1:0] == $past(s_q.cnt[9:8])
   ) else $error("Counter high byte read wrong");

   AST_CAP: assert property (
      md_b == etcb_pkg::MD_CAP && on && cap_hit && !bus_wr
      |=> s_q.cmpb == $past(s_q.cnt) && s_q.flg[etcb_pkg::FLG_B]
   ) else $error("Capture did not load compare B");

   COV_CLR_A: cover property (md_b == etcb_pkg::MD_CMP && ccs && run && am);
   COV_CAP:   cover property (md_b == etcb_pkg::MD_CAP && on && cap_hit);
   COV_CTR:   cover property (md_b == etcb_pkg::MD_PWM && run && s_q.dir_dn ##1 !s_q.dir_dn);

endmodule

// ===== verification/etcb_top_tb_top.sv
// Self-checking bench for the timer channel B block
`timescale 1ns/1ps
module etcb_top_tb_top;
   logic        clk_i, rst_n_i, tick_i, cap_i, rd_s, wr_s, wreq, pa, pb, pbn;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, r, q;
   logic [2:0]  fl;
   int          error_cnt, total_checks;

   etcb_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick_i), .capture_b_input_i(cap_i),
      .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .out_a_pin_o(pa), .out_b_pin_o(pb), .out_b_comp_pin_o(pbn), .match_a_flag_o(fl[0]),
      .match_b_flag_o(fl[1]), .period_match_flag_o(fl[2]));

   ////////////////////////////////////////////////////////////////////////////
   // Request held from one rising edge until the edge that sees waitrequest low
   task automatic acc(input logic we, input logic [3:0] a, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      adr  <= a;
      wdat <= {24'h00_0000, d};
      wr_s <= we;
      rd_s <= !we;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_i);
         if (wreq === 1'b0) break;
      end
      if (k == 50) begin
         error_cnt++;
         $display("[ERR] %0t bus access never acknowledged", $time);
      end
      r = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Wait, bounded, for one match flag
   task automatic wf(input int s, input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         if (fl[s] === 1'b1) break;
      end
   endtask

   task automatic restart(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c0);
      acc(1, 4'h0, 8'h00);
      acc(1, 4'h9, 8'h07);
      acc(1, 4'h1, c1);
      acc(1, 4'h2, c2);
      acc(1, 4'h0, c0);
      repeat (3) @(negedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int i = 0; i < 9; i++) begin
         acc(0, i[3:0], 8'h00);
         chk(r, 32'h0000_0000);
      end
      acc(0, 4'hC, 8'h00);
      chk(r, 32'h0000_0000);
      acc(1, 4'h6, 8'hFF);
      acc(0, 4'h6, 8'h00);
      chk(r, 32'h0000_0003);
      acc(1, 4'h6, 8'h00);
      acc(1, 4'h7, 8'hA5);
      acc(0, 4'h7, 8'h00);
      chk(r, 32'h0000_00A5);
      acc(1, 4'h3, 8'h55);
      acc(0, 4'h3, 8'h00);
      chk(r, 32'h0000_0000);
   endtask

   // Every channel B pin function, initial level and polarity in compare mode
   task automatic t_cmp;
      logic e;
      acc(1, 4'h5, 8'h64);
      acc(1, 4'h7, 8'h28);
      for (int c = 0; c < 16; c++) begin
         e = (c[3:2] == 2'b00) ? c[1] : (c[3:2] == 2'b11) ? !c[1] : c[3];
         restart(8'h21, {2'b00, c[3:0], 2'b00}, 8'h08);
         chk({pb, pbn, pa}, {c[1] ^ c[0], !(c[1] ^ c[0]), 1'b0});
         wf(1, 200);
         chk({fl[1], pb, pbn, pa}, {1'b1, e ^ c[0], !(e ^ c[0]), 1'b0});
         wf(0, 200);
         chk({fl, pa}, 4'b0111);
         acc(0, 4'h3, 8'h00);
         chk(r <= 32'd100, 1'b1);
      end
   endtask

   task automatic t_per;
      restart(8'h00, 8'h00, 8'h09);
      wf(2, 300);
      chk(fl[2], 1'b1);
      acc(1, 4'h0, 8'h00);
      acc(0, 4'h3, 8'h00);
      q = r;
      repeat (10) @(posedge clk_i);
      acc(0, 4'h3, 8'h00);
      chk(r, q);
   endtask

   // Forced levels and edge-aligned duty on the B pins, down-count B matches on the match B flag
   task automatic t_pwm;
      restart(8'h80, 8'h98, 8'h08);
      chk({pb, pbn}, 2'b10);
      restart(8'h80, 8'h9C, 8'h08);
      chk({pb, pbn}, 2'b01);
      restart(8'h80, 8'h88, 8'h08);
      chk({pb, pbn}, 2'b01);
      restart(8'h80, 8'hA8, 8'h08);
      chk({pb, pbn}, 2'b10);
      repeat (50) @(negedge clk_i);
      chk({fl[1], pb, pbn}, 3'b101);
      restart(8'h80, 8'hAA, 8'h09);
      repeat (100) @(negedge clk_i);
      chk(fl[1], 1'b0);
      wf(1, 200);
      chk(fl[1], 1'b1);
   endtask

   // Timer/counter mode: flags as in compare mode, B pins stay low
   task automatic t_tmr;
      restart(8'hC1, 8'hCC, 8'h08);
      wf(1, 100);
      chk({fl[1], pb, pbn}, 3'b100);
   endtask

   task automatic t_cap;
      restart(8'h40, 8'h40, 8'h08);
      repeat (20) @(posedge clk_i);
      cap_i <= 1'b1;
      wf(1, 10);
      chk(fl[1], 1'b1);
      acc(0, 4'h7, 8'h00);
      chk(r, 32'h0000_0015);
   endtask

   task automatic conclude;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = !clk_i;
   end

   initial begin
      #200us;
      error_cnt++;
      conclude();
   end

   initial begin
      {rst_n_i, tick_i, cap_i, rd_s, wr_s, adr, wdat} = '0;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick_i  <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_regs();
      t_cmp();
      t_per();
      t_pwm();
      t_tmr();
      t_cap();
      conclude();
   end
endmodule
